/* hdl/rstpwr_pkg.sv */
// constants, field layout and modes of the reset cause and voltage event controller
package rstpwr_pkg;
  // register byte offsets
  localparam logic [11:0] CAUSE_OFF  = 12'h000;
  localparam logic [11:0] VSTAT_OFF  = 12'h004;
  localparam logic [11:0] VCFG_OFF   = 12'h008;
  localparam logic [11:0] SLPPWR_OFF = 12'h00C;
  localparam logic [11:0] CLKCTL_OFF = 12'h010;
  localparam logic [11:0] SLPEN_OFF  = 12'h014;
  localparam logic [11:0] SWRST_OFF  = 12'h018;
  localparam int          ADDR_W     = 12;

  // reset cause field
  localparam int CAUSE_W       = 6;
  localparam int CAUSE_REG_BIT = 0;
  localparam int CAUSE_SW_BIT  = 1;
  localparam int CAUSE_WD_BIT  = 2;
  localparam int CAUSE_BO_BIT  = 3;
  localparam int CAUSE_PO_BIT  = 4;
  localparam int CAUSE_PIN_BIT = 5;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 6'h10;

  // rails and the asynchronous inputs that pass the synchroniser
  localparam int RAIL_N     = 3;
  localparam int RAIL_MAIN  = 0;
  localparam int RAIL_ANLG  = 1;
  localparam int RAIL_CORE  = 2;
  localparam int ASYNC_N    = 6;
  localparam int IN_REG     = 3;
  localparam int IN_WDOG    = 4;
  localparam int IN_PIN     = 5;
  localparam logic [RAIL_N-1:0] VSTAT_RST = 3'h0;

  // voltage event configuration fields
  localparam int ACT_W        = 2;
  localparam int BOR_TYPE_BIT = 8;
  localparam int VCFG_W       = 9;
  localparam logic [VCFG_W-1:0] VCFG_RST = 9'h000;

  // sleep power, clock control and software reset fields
  localparam int FLASH_BIT   = 0;
  localparam int SRAM_LSB    = 4;
  localparam int GATE_BIT    = 0;
  localparam int USBPLL_BIT  = 1;
  localparam int SWRST_BIT   = 0;

  typedef enum logic [1:0] {act_none, act_irq, act_nmi, act_reset} bo_action_t;
  typedef enum logic {bor_type_system, bor_type_poweron} brownout_reset_type_t;
  typedef enum logic {flash_sleep_full_power, flash_sleep_reduced} flash_sleep_t;
  typedef enum logic [1:0] {sram_sleep_full_power, sram_sleep_standby, sram_sleep_lowest} sram_sleep_t;
endpackage : rstpwr_pkg

/* hdl/reset_cause_and_voltage_event_ctrl.sv */
// reset cause flags, brown-out events and responses, sleep power and clock gating
`timescale 1ns/1ns
`default_nettype none
module reset_cause_and_voltage_event_ctrl #(
  parameter int PERIPH_N = 16
) (
  // clock and power-on reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [rstpwr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // asynchronous monitors and reset sources
  input  wire logic [rstpwr_pkg::RAIL_N-1:0] rail_low,
  input  wire logic                         regulator_fault,
  input  wire logic                         watchdog_reset,
  input  wire logic                         pin_reset,
  // processor core and peripherals
  input  wire logic                         core_sleeping,
  input  wire logic [PERIPH_N-1:0]          periph_irq,
  output logic                              core_wake,
  output logic      [PERIPH_N-1:0]          periph_clk_en,
  // responses
  output logic                              sys_irq,
  output logic                              nmi,
  output logic                              por_req,
  output logic                              sys_reset_req,
  // power controls
  output logic                              flash_low_power,
  output logic      [1:0]                   sram_mode,
  output logic                              usb_phy_pll_on
);
  import rstpwr_pkg::*;

  initial begin
    if (PERIPH_N < 1 || PERIPH_N > 32) begin
      $error("PERIPH_N must lie in 1..32");
    end
  end

  // apb decode
  logic wr_en;
  logic rd_setup;
  logic hit;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit      = (paddr == CAUSE_OFF) || (paddr == VSTAT_OFF) || (paddr == VCFG_OFF) ||
                    (paddr == SLPPWR_OFF) || (paddr == CLKCTL_OFF) || (paddr == SLPEN_OFF) ||
                    (paddr == SWRST_OFF);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;

  function automatic logic wr_at(input logic [ADDR_W-1:0] off);
    wr_at = wr_en && (paddr == off);
  endfunction : wr_at

  // three-stage synchroniser; a level counts once stages two and three agree
  logic [ASYNC_N-1:0] sync1_reg;
  logic [ASYNC_N-1:0] sync2_reg;
  logic [ASYNC_N-1:0] sync3_reg;
  logic [ASYNC_N-1:0] level_reg;
  logic [ASYNC_N-1:0] level_d_reg;
  logic [ASYNC_N-1:0] rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg   <= '0;
      sync2_reg   <= '0;
      sync3_reg   <= '0;
      level_reg   <= '0;
      level_d_reg <= '0;
    end else begin
      sync1_reg   <= {pin_reset, watchdog_reset, regulator_fault, rail_low};
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      level_reg   <= (level_reg & ~(sync2_reg ^ sync3_reg)) | (sync3_reg & ~(sync2_reg ^ sync3_reg));
      level_d_reg <= level_reg;
    end
  end
  assign rise = level_reg & ~level_d_reg;

  // brown-out response per rail
  logic [VCFG_W-1:0] vcfg_reg;
  logic [RAIL_N-1:0] bo_ev;
  logic [RAIL_N-1:0] ev_irq;
  logic [RAIL_N-1:0] ev_nmi;
  logic [RAIL_N-1:0] ev_rst;
  assign bo_ev = rise[RAIL_N-1:0];
  always_comb begin
    for (int i = 0; i < RAIL_N; i++) begin
      ev_irq[i] = bo_ev[i] && (vcfg_reg[ACT_W*i +: ACT_W] == act_irq);
      ev_nmi[i] = bo_ev[i] && (vcfg_reg[ACT_W*i +: ACT_W] == act_nmi);
      ev_rst[i] = bo_ev[i] && (vcfg_reg[ACT_W*i +: ACT_W] == act_reset);
    end
  end

  logic bo_reset;
  logic bo_por;
  logic sw_rst_req;
  logic soft_clr;
  assign bo_reset   = |ev_rst;
  assign bo_por     = bo_reset && (vcfg_reg[BOR_TYPE_BIT] == bor_type_poweron);
  assign sw_rst_req = wr_at(SWRST_OFF) && pwdata[SWRST_BIT];
  // system-type resets return the configuration to defaults but leave the flags
  assign soft_clr   = sw_rst_req || (bo_reset && !bo_por);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_irq       <= 1'b0;
      nmi           <= 1'b0;
      por_req       <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      sys_irq       <= |ev_irq;
      nmi           <= |ev_nmi;
      por_req       <= bo_por;
      sys_reset_req <= soft_clr;
    end
  end

  // reset cause flags: set wins over a same-cycle clear
  logic [CAUSE_W-1:0] cause_reg;
  logic [CAUSE_W-1:0] cause_set;
  logic [CAUSE_W-1:0] cause_clr;
  logic [CAUSE_W-1:0] cause_next;
  always_comb begin
    cause_set                = '0;
    cause_set[CAUSE_REG_BIT] = rise[IN_REG];
    cause_set[CAUSE_SW_BIT]  = sw_rst_req;
    cause_set[CAUSE_WD_BIT]  = rise[IN_WDOG];
    cause_set[CAUSE_BO_BIT]  = bo_reset;
    cause_set[CAUSE_PIN_BIT] = rise[IN_PIN];
    cause_clr  = wr_at(CAUSE_OFF) ? pwdata[CAUSE_W-1:0] : '0;
    cause_next = (cause_reg & ~cause_clr) | cause_set;
  end
  // the power-on flag is the reset value, so every power-on reset shows it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= CAUSE_RST;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // voltage event flags, one per rail
  logic [RAIL_N-1:0] vstat_reg;
  logic [RAIL_N-1:0] vstat_clr;
  assign vstat_clr = wr_at(VSTAT_OFF) ? pwdata[RAIL_N-1:0] : '0;
  // only power-up or a write to VSTAT_OFF clears these; soft_clr and system resets never reach them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vstat_reg <= VSTAT_RST;
    end else begin
      vstat_reg <= (vstat_reg & ~vstat_clr) | bo_ev;
    end
  end

  // configuration registers
  logic                flash_reg;
  logic [1:0]          sram_reg;
  logic                gate_reg;
  logic                pll_reg;
  logic [PERIPH_N-1:0] slpen_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcfg_reg <= VCFG_RST;
    end else if (soft_clr) begin
      vcfg_reg <= VCFG_RST;
    end else if (wr_at(VCFG_OFF)) begin
      vcfg_reg <= pwdata[VCFG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_reg <= flash_sleep_full_power;
      sram_reg  <= sram_sleep_full_power;
    end else if (soft_clr) begin
      flash_reg <= flash_sleep_full_power;
      sram_reg  <= sram_sleep_full_power;
    end else if (wr_at(SLPPWR_OFF)) begin
      flash_reg <= pwdata[FLASH_BIT];
      // the unused fourth code is ignored so the mode stays one of three
      if (pwdata[SRAM_LSB +: 2] != 2'h3) begin
        sram_reg <= pwdata[SRAM_LSB +: 2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg  <= 1'b0;
      pll_reg   <= 1'b0;
      slpen_reg <= '0;
    end else if (soft_clr) begin
      gate_reg  <= 1'b0;
      pll_reg   <= 1'b0;
      slpen_reg <= '0;
    end else begin
      if (wr_at(CLKCTL_OFF)) begin
        gate_reg <= pwdata[GATE_BIT];
        pll_reg  <= pwdata[USBPLL_BIT];
      end
      if (wr_at(SLPEN_OFF)) begin
        slpen_reg <= pwdata[PERIPH_N-1:0];
      end
    end
  end

  // power outputs; the pll gates only the phy, usb register access is untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_low_power <= 1'b0;
      sram_mode       <= sram_sleep_full_power;
      usb_phy_pll_on  <= 1'b0;
    end else begin
      flash_low_power <= core_sleeping && (flash_reg == flash_sleep_reduced);
      sram_mode       <= core_sleeping ? sram_reg : sram_sleep_full_power;
      usb_phy_pll_on  <= pll_reg;
    end
  end

  // sleep clock gating and wake-up
  // wake uses the live mask: the registered clock enables lag sleep entry by a cycle
  logic [PERIPH_N-1:0] wake_mask;
  assign wake_mask = gate_reg ? slpen_reg : '1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clk_en <= '1;
      core_wake     <= 1'b0;
    end else begin
      periph_clk_en <= (core_sleeping && gate_reg) ? slpen_reg : '1;
      core_wake     <= core_sleeping && |(periph_irq & wake_mask);
    end
  end

  // read data is registered in the setup phase, so the access phase needs no wait
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      CAUSE_OFF:  rd_mux[CAUSE_W-1:0] = cause_reg;
      VSTAT_OFF:  rd_mux[RAIL_N-1:0]  = vstat_reg;
      VCFG_OFF:   rd_mux[VCFG_W-1:0]  = vcfg_reg;
      SLPPWR_OFF: begin
        rd_mux[FLASH_BIT]     = flash_reg;
        rd_mux[SRAM_LSB +: 2] = sram_reg;
      end
      CLKCTL_OFF: begin
        rd_mux[GATE_BIT]   = gate_reg;
        rd_mux[USBPLL_BIT] = pll_reg;
      end
      SLPEN_OFF:  rd_mux[PERIPH_N-1:0] = slpen_reg;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // checks
  a_cause_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    rise[IN_WDOG] |=> cause_reg[CAUSE_WD_BIT]) else $error("watchdog cause not set");
  a_cause_clear_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_at(CAUSE_OFF) && (cause_set == '0)) |=> cause_reg == ($past(cause_reg) & ~$past(pwdata[CAUSE_W-1:0])))
    else $error("cause clear touched unselected flags");
  a_cause_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (!wr_at(CAUSE_OFF) && cause_reg[CAUSE_PIN_BIT]) |=> cause_reg[CAUSE_PIN_BIT])
    else $error("pin cause dropped without clear");
  a_swrst_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    sw_rst_req |=> (cause_reg[CAUSE_SW_BIT] && sys_reset_req && vcfg_reg == VCFG_RST))
    else $error("software reset did not keep causes or restore defaults");
  a_vstat_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (soft_clr && !wr_at(VSTAT_OFF)) |=> (vstat_reg & $past(vstat_reg)) == $past(vstat_reg))
    else $error("reset cleared voltage flags");
  a_vstat_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_at(VSTAT_OFF) && bo_ev == '0) |=> vstat_reg == ($past(vstat_reg) & ~$past(pwdata[RAIL_N-1:0])))
    else $error("voltage clear ignored its mask");
  a_rail_event: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(level_reg[RAIL_CORE]) |=> vstat_reg[RAIL_CORE]) else $error("core rail event lost");
  a_irq_resp: assert property (@(posedge pclk) disable iff (!presetn)
    (bo_ev[RAIL_MAIN] && vcfg_reg[1:0] == act_irq) |=> sys_irq) else $error("main rail irq missing");
  a_nmi_only: assert property (@(posedge pclk) disable iff (!presetn)
    nmi == $past(|ev_nmi))
    else $error("nmi does not follow the nmi response");
  a_bor_type: assert property (@(posedge pclk) disable iff (!presetn)
    bo_reset |=> (por_req == $past(vcfg_reg[BOR_TYPE_BIT])) && (sys_reset_req || por_req))
    else $error("brown-out reset of the wrong kind");
  a_gate_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    (core_sleeping && gate_reg && !soft_clr && !wr_at(SLPEN_OFF)) ##1 (core_sleeping && gate_reg)
    |-> periph_clk_en == slpen_reg)
    else $error("gated clocks do not follow sleep enables");
  a_wake_src: assert property (@(posedge pclk) disable iff (!presetn)
    (core_sleeping && |(periph_irq & slpen_reg)) |=> core_wake) else $error("no wake from enabled peripheral");
  a_wake_masked: assert property (@(posedge pclk) disable iff (!presetn)
    (core_sleeping && gate_reg && !(|(periph_irq & slpen_reg))) |=> !core_wake)
    else $error("wake from a peripheral not enabled for sleep");
endmodule : reset_cause_and_voltage_event_ctrl
`default_nettype wire

/* bench/supply_core_model.sv */
// supply monitors, reset sources and processor core driving the controller
`timescale 1ns/1ns
`default_nettype none
module supply_core_model #(
  parameter int PN = 16
) (
  // clock
  input  wire logic          pclk,
  // monitors and reset sources
  output logic [2:0]         rail_low,
  output logic               regulator_fault,
  output logic               watchdog_reset,
  output logic               pin_reset,
  // core
  output logic               core_sleeping,
  output logic [PN-1:0]      periph_irq
);
  initial begin
    rail_low        = 3'h0;
    regulator_fault = 1'b0;
    watchdog_reset  = 1'b0;
    pin_reset       = 1'b0;
    core_sleeping   = 1'b0;
    periph_irq      = '0;
  end

  // rails sag long enough to pass the synchroniser, then recover for a later event
  task automatic brownout(input logic [2:0] m);
    @(posedge pclk) rail_low <= m;
    repeat (8) @(posedge pclk);
    rail_low <= 3'h0;
    repeat (4) @(posedge pclk);
  endtask : brownout

  // k: 0 regulator, 1 watchdog, 2 pin
  task automatic src(input int k);
    @(posedge pclk);
    regulator_fault <= (k == 0);
    watchdog_reset  <= (k == 1);
    pin_reset       <= (k == 2);
    repeat (8) @(posedge pclk);
    regulator_fault <= 1'b0;
    watchdog_reset  <= 1'b0;
    pin_reset       <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : src

  task automatic core(input logic s, input logic [PN-1:0] irq);
    @(posedge pclk) core_sleeping <= s;
    periph_irq <= irq;
    repeat (3) @(posedge pclk);
  endtask : core
endmodule : supply_core_model
`default_nettype wire

/* bench/reset_cause_and_voltage_event_ctrl_tb_top.sv */
// self-checking bench for the reset cause and voltage event controller
`timescale 1ns/1ns
`default_nettype none
module reset_cause_and_voltage_event_ctrl_tb_top;
  import rstpwr_pkg::*;
  localparam int PN = 16;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [2:0]        rail_low;
  logic              regulator_fault, watchdog_reset, pin_reset, core_sleeping, core_wake;
  logic [PN-1:0]     periph_irq, periph_clk_en;
  logic              sys_irq, nmi, por_req, sys_reset_req, flash_low_power, usb_phy_pll_on;
  logic [1:0]        sram_mode;
  int                fail_count, n_tests, pc[4];

  reset_cause_and_voltage_event_ctrl #(.PERIPH_N(PN)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rail_low(rail_low), .regulator_fault(regulator_fault), .watchdog_reset(watchdog_reset),
    .pin_reset(pin_reset), .core_sleeping(core_sleeping), .periph_irq(periph_irq), .core_wake(core_wake),
    .periph_clk_en(periph_clk_en), .sys_irq(sys_irq), .nmi(nmi), .por_req(por_req),
    .sys_reset_req(sys_reset_req), .flash_low_power(flash_low_power), .sram_mode(sram_mode),
    .usb_phy_pll_on(usb_phy_pll_on));
  supply_core_model #(.PN(PN)) mdl (.pclk(pclk), .rail_low(rail_low), .regulator_fault(regulator_fault),
    .watchdog_reset(watchdog_reset), .pin_reset(pin_reset), .core_sleeping(core_sleeping),
    .periph_irq(periph_irq));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // pulse outputs are counted so a missing or doubled pulse shows up
  always @(posedge pclk) begin
    pc[0] += (sys_irq === 1'b1);
    pc[1] += (nmi === 1'b1);
    pc[2] += (por_req === 1'b1);
    pc[3] += (sys_reset_req === 1'b1);
  end

  task automatic finish_test;
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task automatic t_cause;
    rchk(CAUSE_OFF, 32'h10);
    apb(1'b0, 12'h100, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    mdl.src(1);
    mdl.src(2);
    rchk(CAUSE_OFF, 32'h34);
    apb(1'b1, CAUSE_OFF, 32'h04);
    rchk(CAUSE_OFF, 32'h30);
    mdl.src(1);
    mdl.src(0);
    rchk(CAUSE_OFF, 32'h35);
    apb(1'b1, CAUSE_OFF, 32'h0);
    rchk(CAUSE_OFF, 32'h35);
    apb(1'b1, CAUSE_OFF, 32'h3F);
    rchk(CAUSE_OFF, 32'h0);
  endtask : t_cause

  task automatic t_swrst;
    int b;
    mdl.brownout(3'h2);
    apb(1'b1, VCFG_OFF, 32'h155);
    b = pc[3];
    apb(1'b1, SWRST_OFF, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(pc[3] - b), 32'h1);
    rchk(CAUSE_OFF, 32'h02);
    rchk(VCFG_OFF, 32'h0);
    rchk(VSTAT_OFF, 32'h2);
    apb(1'b1, CAUSE_OFF, 32'h3F);
    apb(1'b1, VSTAT_OFF, 32'h7);
  endtask : t_swrst

  // every rail with every response; reset response uses the system type, then one power-on type reset of the main rail
  task automatic t_rails;
    int b[4];
    logic [3:0] e;
    for (int r = 0; r < 3; r++) begin
      for (int a = 0; a < 4; a++) begin
        e = (a == 0) ? 4'h0 : 4'(1 << ((a == 3) ? 3 : a - 1));
        apb(1'b1, VCFG_OFF, 32'(a << (2 * r)));
        b = pc;
        mdl.brownout(3'(1 << r));
        for (int k = 0; k < 4; k++) chk(32'(pc[k] - b[k]), {31'h0, e[k]});
        rchk(VSTAT_OFF, 32'(1 << r));
        rchk(CAUSE_OFF, (a == 3) ? 32'h08 : 32'h0);
        apb(1'b1, CAUSE_OFF, 32'h3F);
        apb(1'b1, VSTAT_OFF, 32'(1 << r));
      end
    end
    mdl.brownout(3'h5);
    apb(1'b1, VSTAT_OFF, 32'h1);
    rchk(VSTAT_OFF, 32'h4);
    apb(1'b1, VCFG_OFF, 32'h103);
    b = pc;
    mdl.brownout(3'h1);
    chk(32'(pc[2] - b[2]), 32'h1);
    chk(32'(pc[3] - b[3]), 32'h0);
    do_reset();
    rchk(CAUSE_OFF, 32'h10);
  endtask : t_rails

  task automatic t_sleep;
    apb(1'b1, CLKCTL_OFF, 32'h3);
    repeat (2) @(posedge pclk);
    chk({31'h0, usb_phy_pll_on}, 32'h1);
    apb(1'b1, SLPEN_OFF, 32'h5);
    mdl.core(1'b1, 16'h0002);
    chk({16'h0, periph_clk_en}, 32'h5);
    chk({31'h0, core_wake}, 32'h0);
    mdl.core(1'b1, 16'h0004);
    chk({31'h0, core_wake}, 32'h1);
    apb(1'b1, CLKCTL_OFF, 32'h0);
    mdl.core(1'b1, 16'h0);
    chk({16'h0, periph_clk_en}, 32'hFFFF);
    chk({31'h0, usb_phy_pll_on}, 32'h0);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, SLPPWR_OFF, 32'((s << 4) | (s & 1)));
      repeat (2) @(posedge pclk);
      chk({29'h0, sram_mode, flash_low_power}, 32'((s << 1) | (s & 1)));
    end
    apb(1'b1, SLPPWR_OFF, 32'h30);
    repeat (2) @(posedge pclk);
    chk({29'h0, sram_mode, flash_low_power}, 32'h4);
    rchk(SLPPWR_OFF, 32'h20);
    mdl.core(1'b0, 16'h0);
    chk({29'h0, sram_mode, flash_low_power}, 32'h0);
  endtask : t_sleep

  initial begin
    #(40 * 20000);
    fail_count++;
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    fail_count = 0;
    n_tests = 0;
    pc = '{0, 0, 0, 0};
    do_reset();
    t_cause();
    t_swrst();
    t_rails();
    t_sleep();
    finish_test();
  end
endmodule : reset_cause_and_voltage_event_ctrl_tb_top
`default_nettype wire
